// ==== core/srt_pkg.sv ====
// constants and types shared by the supervisor reset timing block
package srt_pkg;
    // clock rate in kHz (10 MHz)
    localparam int unsigned CLK_KHZ            = 10000;
    // recovery hold time, typical, in ms
    localparam int unsigned RECOVERY_HOLD_MS   = 210;
    // recovery hold time guaranteed floor, in ms
    localparam int unsigned RECOVERY_MIN_MS    = 140;
    localparam int unsigned RECOVERY_HOLD_CYC  = RECOVERY_HOLD_MS * CLK_KHZ;
    // long press setup times, typical, in ms per build letter
    localparam int unsigned SETUP_K_MS         = 10080;
    localparam int unsigned SETUP_L_MS         = 6720;
    localparam int unsigned SETUP_S_MS         = 3360;
    localparam int unsigned SETUP_T_MS         = 1680;
    localparam int unsigned SETUP_T_CYC        = SETUP_T_MS * CLK_KHZ;
    // immediate input: accepted after 1 us low, 100 ns glitches rejected
    localparam int unsigned IMMED_MIN_NS       = 1000;
    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam int unsigned IMMED_MIN_CYC      = IMMED_MIN_NS / CLK_PERIOD_NS;
    // fault to reset delays in us, the logic reacts far quicker
    localparam int unsigned ADJ_FAULT_US       = 15;
    localparam int unsigned MAIN_FAULT_US      = 20;
    // input options for the second manual input
    localparam logic [1:0]  SRT_IN_SINGLE      = 2'h0;
    localparam logic [1:0]  SRT_IN_DUAL_LONG   = 2'h1;
    localparam logic [1:0]  SRT_IN_IMMEDIATE   = 2'h2;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SRT_RUN     = 3'h1,
        SRT_FAULT   = 3'h2,
        SRT_HOLD    = 3'h4
    } srt_state_type;
endpackage : srt_pkg

// ==== core/srt_low_timer.sv ====
`timescale 1ns/1ps
// counts how long a synchronised input has stayed low, fires once per press
module srt_low_timer #(
    parameter int unsigned LIMIT = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // synchronised active-low input and its one-shot result
    input  wire logic level_b,
    output logic      fired
);
    localparam int unsigned CW = $clog2(LIMIT + 1);

    initial begin
        if (LIMIT < 1) begin
            $error("srt_low_timer: LIMIT must be at least one");
        end
    end

    logic [CW-1:0] count_r;   // cycles low so far, saturates at LIMIT
    logic          done_r;    // press already fired, wait for release

    // any high level restarts the count, so short presses never fire
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
            done_r  <= 1'b0;
            fired   <= 1'b0;
        end else if (level_b) begin
            count_r <= '0;
            done_r  <= 1'b0;
            fired   <= 1'b0;
        end else if (count_r == CW'(LIMIT - 1) && !done_r) begin
            // one pulse only, even if the input stays low for ever
            count_r <= CW'(LIMIT);
            done_r  <= 1'b1;
            fired   <= 1'b1;
        end else begin
            if (count_r < CW'(LIMIT)) begin
                count_r <= count_r + 1'b1;
            end
            fired <= 1'b0;
        end
    end
endmodule : srt_low_timer

// ==== core/srt_supervisor.sv ====
`timescale 1ns/1ps
// reset sequencer of a small supply supervisor with long-press manual inputs
// What this block does
// - any supply fault asserts reset low
// - hold reset recovery time after supplies recover
// - long press gives one reset pulse
// - short presses produce no reset
// - setup period fixed at build time
// - option: two long-press inputs, shared one-shot
// - option: one long plus one immediate input
// - immediate input needs 1 us, rejects glitches
// - adjustable monitor fault asserts within 15 us
// - main supply fault asserts within 20 us
// - active-low output, push-pull or open-drain
module srt_supervisor #(
    parameter int unsigned SETUP_CYC    = srt_pkg::SETUP_T_CYC,
    parameter int unsigned HOLD_CYC     = srt_pkg::RECOVERY_HOLD_CYC,
    parameter logic [1:0]  INPUT_MODE   = srt_pkg::SRT_IN_SINGLE,
    parameter bit          ADJ_MONITOR  = 1'b0,
    parameter bit          OPEN_DRAIN   = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // comparator outputs, low means the supply is below threshold
    input  wire logic main_supply_ok,
    input  wire logic adjustable_monitor_in,
    // manual reset buttons, active low
    input  wire logic long_press_input_a_b,
    input  wire logic second_press_input_b_b,
    // reset output pin: level, output enable (low drives)
    output logic      reset_out_b,
    output logic      reset_oe_b
);
    localparam int unsigned HW = $clog2(HOLD_CYC + 1);

    initial begin
        if (HOLD_CYC < 1 || SETUP_CYC < 1) begin
            $error("srt_supervisor: counts must be at least one");
        end
        if (INPUT_MODE > srt_pkg::SRT_IN_IMMEDIATE) begin
            $error("srt_supervisor: unknown input mode");
        end
    end

    // two-flop synchronisers for all pin inputs
    logic [3:0] sync1_r;      // first stage, read only by sync2_r
    logic [3:0] sync2_r;      // stable copies
    logic [3:0] pins;
    assign pins = {second_press_input_b_b, long_press_input_a_b,
                   adjustable_monitor_in, main_supply_ok};

    // every pin idles high (supply good, button released)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    logic main_ok_s;
    logic adj_ok_s;
    logic long_a_s;
    logic second_s;
    assign main_ok_s = sync2_r[0];
    assign adj_ok_s  = sync2_r[1];
    assign long_a_s  = sync2_r[2];
    assign second_s  = sync2_r[3];

    // fault as soon as the synchronised comparator drops
    logic supply_fault;
    assign supply_fault = !main_ok_s || (ADJ_MONITOR && !adj_ok_s);

    // dual long-press: both buttons held together feed the timer
    logic long_level_b;
    always_comb begin
        if (INPUT_MODE == srt_pkg::SRT_IN_DUAL_LONG) begin
            long_level_b = long_a_s | second_s;
        end else begin
            long_level_b = long_a_s;
        end
    end

    // long press fires once after the build-time setup period
    logic long_fire;
    srt_low_timer #(
        .LIMIT   (SETUP_CYC)
    ) u_long_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .level_b (long_level_b),
        .fired   (long_fire)
    );

    // immediate input; 1 us filter rejects 100 ns glitches
    logic immed_fire;
    logic immed_level_b;
    assign immed_level_b = (INPUT_MODE == srt_pkg::SRT_IN_IMMEDIATE) ? second_s : 1'b1;
    srt_low_timer #(
        .LIMIT   (srt_pkg::IMMED_MIN_CYC)
    ) u_immed_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .level_b (immed_level_b),
        .fired   (immed_fire)
    );

    logic manual_fire;
    assign manual_fire = long_fire | immed_fire;

    // sequencer state and hold counter
    srt_pkg::srt_state_type state_r;
    srt_pkg::srt_state_type state_nxt;
    logic [HW-1:0]          hold_r;

    // next state: fault dominates, hold restarts on a fresh event
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            srt_pkg::SRT_RUN: begin
                if (supply_fault) begin
                    state_nxt = srt_pkg::SRT_FAULT;
                end else if (manual_fire) begin
                    state_nxt = srt_pkg::SRT_HOLD;
                end
            end
            srt_pkg::SRT_FAULT: begin
                if (!supply_fault) begin
                    state_nxt = srt_pkg::SRT_HOLD;
                end
            end
            srt_pkg::SRT_HOLD: begin
                // a fault in the pulse falls back to waiting
                if (supply_fault) begin
                    state_nxt = srt_pkg::SRT_FAULT;
                end else if (hold_r == HW'(1) && !manual_fire) begin
                    state_nxt = srt_pkg::SRT_RUN;
                end
            end
            default: begin
                state_nxt = srt_pkg::SRT_FAULT;
            end
        endcase
    end

    // power-on starts in fault so the output waits for a full hold
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= srt_pkg::SRT_FAULT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // hold counter loads on entry, reloads on a new press
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= HW'(HOLD_CYC);
        end else if (state_nxt != srt_pkg::SRT_HOLD) begin
            hold_r <= HW'(HOLD_CYC);
        end else if (state_r != srt_pkg::SRT_HOLD || manual_fire) begin
            hold_r <= HW'(HOLD_CYC);
        end else begin
            hold_r <= hold_r - 1'b1;
        end
    end

    // output register; asserted in any state but run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_out_b <= 1'b0;
        end else begin
            reset_out_b <= (state_nxt == srt_pkg::SRT_RUN);
        end
    end

    // open drain releases the pin for high, push-pull always drives
    always_comb begin
        if (OPEN_DRAIN) begin
            reset_oe_b = reset_out_b;
        end else begin
            reset_oe_b = 1'b0;
        end
    end

    // watchers for the assertions
    sequence fault_seen_s;
        !main_ok_s || (ADJ_MONITOR && !adj_ok_s);
    endsequence

    // fault pulls reset low on the next edge
    fault_asserts_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            fault_seen_s |=> !reset_out_b)
        else $error("supply fault did not assert reset");

    // release never earlier than the hold count after the fault clears
    recovery_hold_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            (state_r == srt_pkg::SRT_FAULT && !supply_fault) |=>
                (state_r == srt_pkg::SRT_HOLD) && hold_r == HW'(HOLD_CYC))
        else $error("hold did not start with full count");

    release_only_end_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            $rose(reset_out_b) |-> $past(hold_r) == HW'(1))
        else $error("reset released before hold expired");

    manual_pulse_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            (manual_fire && !supply_fault) |=> !reset_out_b [*2])
        else $error("manual press gave no reset pulse");

    // fault during hold returns to fault state
    fault_in_pulse_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            (state_r == srt_pkg::SRT_HOLD && supply_fault) |=>
                state_r == srt_pkg::SRT_FAULT)
        else $error("fault during pulse not honoured");

    // no reset from the button unless the timer fired
    short_press_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            (state_r == srt_pkg::SRT_RUN && !supply_fault && !manual_fire)
                |=> reset_out_b)
        else $error("reset without cause");

    drive_mode_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            !OPEN_DRAIN |-> !reset_oe_b)
        else $error("push-pull output not driven");

    // immediate input fires only in its mode
    immed_mode_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            immed_fire |-> INPUT_MODE == srt_pkg::SRT_IN_IMMEDIATE)
        else $error("immediate fire in wrong mode");
endmodule : srt_supervisor

// ==== tb/srt_host_model.sv ====
// reset receiver model: measures every reset pulse seen at the pin
`timescale 1ns/1ps
module srt_host_model (
    // clock
    input  wire logic        clk,
    // resolved reset pin, active low, pulled up when released
    input  wire logic        reset_pin_b,
    // released pulses so far and low length of the last one
    output logic [15:0]      rel_count,
    output logic [15:0]      last_len
);
    // cycles the pin has been low; preset as the receiver has no reset
    logic [15:0] low_cnt = 16'h0000;
    initial rel_count = 16'h0000;
    initial last_len  = 16'h0000;
    // count low cycles, latch the length when the pin rises
    // plain always: the initial presets above also write these outputs
    always @(posedge clk) begin
        if (!reset_pin_b) begin
            low_cnt <= low_cnt + 16'h0001;
        end else if (low_cnt != 16'h0000) begin
            last_len  <= low_cnt;
            rel_count <= rel_count + 16'h0001;
            low_cnt   <= 16'h0000;
        end
    end
endmodule : srt_host_model

// ==== tb/supervisor_reset_timing_tb.sv ====
// self-checking bench for the supervisor reset timing block
`timescale 1ns/1ps
module supervisor_reset_timing_tb;
    localparam int unsigned SETUP = 20;  // shortened long-press setup
    localparam int unsigned HOLD  = 30;  // shortened recovery hold
    logic        clk = 1'b0;   // 10 MHz
    logic        rst_b;        // async reset, active low
    logic        main_ok;      // main comparator
    logic        adj_ok;       // adjustable comparator
    logic        btn_a_b;      // long-press button
    logic        btn_b_b;      // immediate button
    logic        out_b;        // reset level
    logic        oe_b;         // pin enable, low drives
    logic        pin_b;        // resolved pin
    logic [15:0] rel;          // pulses released
    logic [15:0] len;          // last pulse length
    logic        out2_b;       // dual-long variant reset level
    logic        oe2_b;        // dual-long variant pin enable
    logic        pin2_b;       // dual-long variant resolved pin
    logic [15:0] rel2;         // dual-long variant pulses released
    logic [15:0] len2;         // dual-long variant last pulse length
    int          n_mismatch = 0;
    int          checked = 0;
    int          i;
    always #50 clk = ~clk;
    // open drain with pull-up: released pin reads high
    assign pin_b = oe_b ? 1'b1 : out_b;
    srt_supervisor #(.SETUP_CYC(SETUP), .HOLD_CYC(HOLD), .INPUT_MODE(srt_pkg::SRT_IN_IMMEDIATE),
        .ADJ_MONITOR(1'b1), .OPEN_DRAIN(1'b1)) DUT (.clk(clk), .rst_b(rst_b),
        .main_supply_ok(main_ok), .adjustable_monitor_in(adj_ok),
        .long_press_input_a_b(btn_a_b), .second_press_input_b_b(btn_b_b),
        .reset_out_b(out_b), .reset_oe_b(oe_b));
    srt_host_model host (.clk(clk), .reset_pin_b(pin_b), .rel_count(rel), .last_len(len));
    // dual long-press, main supply only, push-pull variant on the same pins
    assign pin2_b = oe2_b ? 1'b1 : out2_b;
    srt_supervisor #(.SETUP_CYC(SETUP), .HOLD_CYC(HOLD), .INPUT_MODE(srt_pkg::SRT_IN_DUAL_LONG),
        .ADJ_MONITOR(1'b0), .OPEN_DRAIN(1'b0)) DUT2 (.clk(clk), .rst_b(rst_b),
        .main_supply_ok(main_ok), .adjustable_monitor_in(adj_ok),
        .long_press_input_a_b(btn_a_b), .second_press_input_b_b(btn_b_b),
        .reset_out_b(out2_b), .reset_oe_b(oe2_b));
    srt_host_model host2 (.clk(clk), .reset_pin_b(pin2_b), .rel_count(rel2), .last_len(len2));
    // one comparison, counted
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // wait for one released pulse, bounded, and check its length
    task automatic pulse(input int lo, input int hi);
        logic [15:0] r0;
        int          k;
        r0 = rel;
        k = 0;
        while (rel === r0 && k < 400) begin
            @(negedge clk);
            k++;
        end
        check({16'h0000, rel}, {16'h0000, r0 + 16'h0001});
        check({31'h0, (len >= lo && len <= hi)}, 32'h1);
    endtask : pulse
    // nothing may happen: pin released, no new pulse
    task automatic quiet(input int n);
        logic [15:0] r0;
        r0 = rel;
        repeat (n) @(negedge clk);
        check({16'h0000, rel}, {16'h0000, r0});
        check({30'h0, pin_b, oe_b}, 32'h3);
    endtask : quiet
    // counts, verdict and end of run
    task automatic results();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        rst_b = 1'b0;
        main_ok = 1'b1;
        adj_ok = 1'b1;
        btn_a_b = 1'b1;
        btn_b_b = 1'b1;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        pulse(HOLD, HOLD + 30);
        check({16'h0000, rel2}, 32'h1);
        $display("test power_on done");
        // main then adjustable supply fault, short dip
        for (i = 0; i < 2; i++) begin
            if (i == 0) main_ok = 1'b0;
            else adj_ok = 1'b0;
            repeat (4) @(negedge clk);
            check({30'h0, pin_b, oe_b}, 32'h0);
            check({30'h0, pin2_b, oe2_b}, (i == 0) ? 32'h0 : 32'h2);
            repeat (6) @(negedge clk);
            main_ok = 1'b1;
            adj_ok = 1'b1;
            pulse(HOLD + 7, HOLD + 13);
        end
        $display("test supply_fault done");
        // short long-press and a 100 ns glitch on the immediate input
        btn_a_b = 1'b0;
        repeat (SETUP - 4) @(negedge clk);
        btn_a_b = 1'b1;
        btn_b_b = 1'b0;
        @(negedge clk);
        btn_b_b = 1'b1;
        quiet(HOLD + 10);
        $display("test short_press done");
        // long press held past firing gives exactly one pulse
        btn_a_b = 1'b0;
        pulse(HOLD - 1, HOLD + 4);
        quiet(40);
        btn_a_b = 1'b1;
        repeat (5) @(negedge clk);
        $display("test long_press done");
        // immediate input low 1.4 us
        btn_b_b = 1'b0;
        repeat (14) @(negedge clk);
        btn_b_b = 1'b1;
        pulse(HOLD - 1, HOLD + 4);
        check({16'h0000, rel2}, 32'h2);
        $display("test immediate done");
        // both buttons: immediate fires first, long press restarts the hold
        btn_a_b = 1'b0;
        btn_b_b = 1'b0;
        repeat (SETUP + 5) @(negedge clk);
        btn_a_b = 1'b1;
        btn_b_b = 1'b1;
        pulse(HOLD + 8, HOLD + 12);
        check({16'h0000, rel2}, 32'h3);
        check({31'h0, (len2 >= HOLD - 1 && len2 <= HOLD + 4)}, 32'h1);
        $display("test dual_press done");
        // supply fault inside a manual pulse stretches it
        btn_a_b = 1'b0;
        repeat (SETUP + 10) @(negedge clk);
        btn_a_b = 1'b1;
        main_ok = 1'b0;
        repeat (50) @(negedge clk);
        main_ok = 1'b1;
        pulse(HOLD + 50, HOLD + 64);
        check({16'h0000, rel2}, 32'h4);
        check({31'h0, (len2 >= HOLD + 50 && len2 <= HOLD + 64)}, 32'h1);
        $display("test fault_in_pulse done");
        results();
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule : supervisor_reset_timing_tb
